/* File: host_mode_defs.vh */
// Constants for the host interface mode select block
`ifndef HOST_MODE_DEFS_VH
`define HOST_MODE_DEFS_VH

// Format strap levels
`define FMT_REG_CONTENT     1'h1
`define FMT_CMD_PARAM       1'h0

// Mode strap field positions
`define STRAP_TOP           2
`define STRAP_MID           1
`define STRAP_LOW           0

// Mode strap codes for the parallel widths
`define STRAP_PAR18         3'h0
`define STRAP_PAR9          3'h1
`define STRAP_PAR16         3'h2
`define STRAP_PAR8          3'h3

// One-hot interface mode codes
`define MODE_NONE           6'h00
`define MODE_PAR18          6'h01
`define MODE_PAR9           6'h02
`define MODE_PAR16          6'h04
`define MODE_PAR8           6'h08
`define MODE_SER3           6'h10
`define MODE_SER4           6'h20

// Lane masks for each width
`define LANES_PAR18         18'h3_ffff
`define LANES_PAR9          18'h3_fe00
`define LANES_PAR16         18'h3_fdfe
`define LANES_PAR8          18'h3_fc00
`define LANES_NONE          18'h0_0000

// Pixel format command and reset value
`define CMD_PIXEL_FORMAT    8'h17
`define PIXFMT_565          1'h0
`define PIXFMT_666          1'h1
`define PIXFMT_RESET        1'h1

// Settle cycles after reset release before straps are caught
`define STRAP_SETTLE        2'h2

`endif

/* File: strap_latch.v */
// Register that catches the straps once after reset release
`timescale 1ns/1ps
module strap_latch (
  input  wire       clk,        // System clock
  input  wire       rst_n,      // Synchronous reset, active low
  input  wire       capture,    // One-cycle capture enable
  input  wire [3:0] straps_in,  // Format and mode straps
  output reg  [3:0] straps_q    // Captured straps
);

  // ==========================================================
  // Capture register
  always @(posedge clk) begin
    if (!rst_n) begin
      straps_q <= 4'h0;
    end else if (capture) begin
      straps_q <= straps_in;
    end
  end

endmodule // strap_latch

/* File: host_interface_mode_select.v */
// Host port mode selection, lane mapping and pixel format hold
//
// Notes on behaviour
// - Format strap high: register-content, low: command-parameter
// - Mode straps decoded only under register-content format
// - Straps 000: 18-bit bus, all lines
// - Straps 001: 9-bit bus, upper nine lines
// - Straps 010: 16-bit, lines 17-10, 8-1
// - Straps 011: 8-bit bus on lines 17-10
// - Straps 10x: three-wire serial, low strap identity
// - Straps 11x: four-wire serial, low strap ignored
// - Pixel format set by command, applied here
// - Accesses honoured only while chip select low
// - Select line marks command or data transfer
`timescale 1ns/1ps
`include "host_mode_defs.vh"
module host_interface_mode_select (
  input  wire        clk,                   // System clock, 25 MHz
  input  wire        rst_n,                 // Synchronous reset, active low
  input  wire        format_select_strap,   // Interface format strap
  input  wire [2:0]  interface_type_straps, // Interface mode straps
  input  wire        chip_select_low,       // Chip select, active low
  input  wire        data_command_select,   // High data, low command
  input  wire        write_strobe,          // One-cycle host write strobe
  input  wire [17:0] parallel_lines,        // Parallel data lines in
  output reg         reg_content_mode,      // Register-content format chosen
  output reg  [5:0]  interface_mode,        // One-hot interface mode
  output reg         serial_identity_bit,   // Identity bit in 3-wire mode
  output reg         straps_valid,          // Straps captured and held
  output reg  [17:0] lane_mask,             // Lanes carrying data
  output reg  [17:0] lane_data,             // Masked write data
  output reg         lane_cmd,              // Last write was a command
  output reg         lane_valid,            // One-cycle accepted write pulse
  output reg         pixel_format_666       // Pixel format, high for 6:6:6
);

  // ==========================================================
  // One-hot capture sequencer states
  // Only two states: settle after reset, then hold until the next reset
  localparam ST_SETTLE = 2'b01;
  localparam ST_HOLD   = 2'b10;

  // ==========================================================
  // Sequencer, caught straps and write path state
  reg  [1:0] state_q;
  reg  [1:0] state_d;
  reg  [1:0] settle_q;
  wire       capture;
  wire [3:0] straps_q;
  wire       fmt_q;
  wire [2:0] im_q;
  wire [5:0] mode_dec;
  wire       write_take;
  wire       pixfmt_hit;
  reg        pix_pending_q;

  // Decode the caught straps to a one-hot mode
  // The top strap wins over the parallel codes; the low strap is the
  // identity bit in three-wire mode and is ignored in four-wire mode
  function [5:0] decode_mode;
    input       fmt;
    input [2:0] im;
    begin
      if (fmt != `FMT_REG_CONTENT) begin
        decode_mode = `MODE_NONE;
      end else if (im[`STRAP_TOP] && im[`STRAP_MID]) begin
        decode_mode = `MODE_SER4;
      end else if (im[`STRAP_TOP]) begin
        decode_mode = `MODE_SER3;
      end else if (im == `STRAP_PAR18) begin
        decode_mode = `MODE_PAR18;
      end else if (im == `STRAP_PAR9) begin
        decode_mode = `MODE_PAR9;
      end else if (im == `STRAP_PAR16) begin
        decode_mode = `MODE_PAR16;
      end else begin
        decode_mode = `MODE_PAR8;
      end
    end
  endfunction

  // Lane mask per one-hot mode
  function [17:0] mode_lanes;
    input [5:0] mode;
    begin
      case (mode)
        `MODE_PAR18: mode_lanes = `LANES_PAR18;
        `MODE_PAR9:  mode_lanes = `LANES_PAR9;
        `MODE_PAR16: mode_lanes = `LANES_PAR16;
        `MODE_PAR8:  mode_lanes = `LANES_PAR8;
        default:     mode_lanes = `LANES_NONE;
      endcase
    end
  endfunction

  // True when one command lane carries the pixel format opcode
  function is_pixfmt_cmd;
    input [7:0] lane_byte;
    begin
      is_pixfmt_cmd = (lane_byte == `CMD_PIXEL_FORMAT);
    end
  endfunction

  // ==========================================================
  // Capture sequencer: wait, catch once, then hold
  always @* begin
    state_d = state_q;
    case (state_q)
      ST_SETTLE: begin
        if (settle_q == `STRAP_SETTLE) begin
          state_d = ST_HOLD;
        end
      end
      ST_HOLD: begin
        state_d = ST_HOLD;
      end
      // Stray codes fall back to the settle state
      default: begin
        state_d = ST_SETTLE;
      end
    endcase
  end

  // Capture pulse: one cycle at the end of the settle count
  assign capture = (state_q == ST_SETTLE) && (settle_q == `STRAP_SETTLE);

  // Sequencer and settle counter; the counter parks at its end value,
  // and the sequencer leaves settle, so capture fires once per reset
  always @(posedge clk) begin
    if (!rst_n) begin
      state_q  <= ST_SETTLE;
      settle_q <= 2'h0;
    end else begin
      state_q <= state_d;
      if (state_q == ST_SETTLE && settle_q != `STRAP_SETTLE) begin
        settle_q <= settle_q + 2'h1;
      end
    end
  end

  // Strap register, loaded by the single capture pulse
  strap_latch u_strap_latch (
    .clk       (clk),
    .rst_n     (rst_n),
    .capture   (capture),
    .straps_in ({format_select_strap, interface_type_straps}),
    .straps_q  (straps_q)
  );

  // Split the caught straps into format and mode fields
  assign fmt_q = straps_q[3];
  assign im_q  = straps_q[2:0];

  // ==========================================================
  // Registered mode outputs, updated once, the cycle after capture
  // Straps are read once; later strap motion waits for the next reset
  // Serial modes report the mode only, with an empty lane mask
  assign mode_dec = decode_mode(fmt_q, im_q);

  // Mode registers, loaded once when the sequencer reaches hold
  always @(posedge clk) begin
    if (!rst_n) begin
      reg_content_mode    <= 1'b0;
      interface_mode      <= `MODE_NONE;
      serial_identity_bit <= 1'b0;
      straps_valid        <= 1'b0;
      lane_mask           <= `LANES_NONE;
    end else if (state_q == ST_HOLD && !straps_valid) begin
      reg_content_mode    <= (fmt_q == `FMT_REG_CONTENT);
      interface_mode      <= mode_dec;
      serial_identity_bit <= (mode_dec == `MODE_SER3) & im_q[`STRAP_LOW];
      straps_valid        <= 1'b1;
      lane_mask           <= mode_lanes(mode_dec);
    end
  end

  // ==========================================================
  // Write acceptance: straps held, a parallel mode and chip selected
  // Serial and command-parameter modes leave the mask empty, so no write lands
  assign write_take = straps_valid && (lane_mask != `LANES_NONE)
                      && !chip_select_low && write_strobe;

  // Pixel format opcode seen on either command lane
  // Both lanes are watched, so narrow and wide buses share one detector
  assign pixfmt_hit = is_pixfmt_cmd(parallel_lines[17:10])
                      || is_pixfmt_cmd(parallel_lines[8:1]);

  // ==========================================================
  // Lane capture: masked data, command flag and one-cycle valid pulse
  // Data and flag stand until the next accepted write
  always @(posedge clk) begin
    if (!rst_n) begin
      lane_data  <= 18'h0_0000;
      lane_cmd   <= 1'b0;
      lane_valid <= 1'b0;
    end else begin
      lane_valid <= write_take;
      if (write_take) begin
        lane_data <= parallel_lines & lane_mask;
        lane_cmd  <= !data_command_select;
      end
    end
  end

  // ==========================================================
  // Pixel format tracker: a command arms it, the next data write applies it
  // A further command before data re-arms or disarms, so an opcode that is
  // followed by some other command never touches the format
  always @(posedge clk) begin
    if (!rst_n) begin
      pixel_format_666 <= `PIXFMT_RESET;
      pix_pending_q    <= 1'b0;
    end else if (write_take) begin
      if (!data_command_select) begin
        pix_pending_q <= pixfmt_hit;
      end else if (pix_pending_q) begin
        pixel_format_666 <= parallel_lines[17] | parallel_lines[8];
        pix_pending_q    <= 1'b0;
      end
    end
  end

endmodule // host_interface_mode_select

/* File: host_mode_properties.sv */
// Checker for host mode select ports
`timescale 1ns/1ps
`include "host_mode_defs.vh"
module host_mode_props (
  input wire logic        clk,                 // Clock
  input wire logic        rst_n,               // Reset, active low
  input wire logic        chip_select_low,     // Chip select, active low
  input wire logic        data_command_select, // Data high, command low
  input wire logic        write_strobe,        // Write strobe
  input wire logic [17:0] parallel_lines,      // Data lines in
  input wire logic        reg_content_mode,    // Register-content format
  input wire logic [5:0]  interface_mode,      // One-hot mode
  input wire logic        serial_identity_bit, // Identity bit
  input wire logic        straps_valid,        // Straps held
  input wire logic [17:0] lane_mask,           // Lanes in use
  input wire logic [17:0] lane_data,           // Masked write data
  input wire logic        lane_cmd,            // Write was a command
  input wire logic        lane_valid,          // Accepted write pulse
  input wire logic        pixel_format_666     // Pixel format
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);
  // ==========
  // Properties
  property p_acc; write_strobe && !chip_select_low && straps_valid && |lane_mask |=> lane_valid;
  endproperty
  a_acc: assert property (p_acc) else $error("write lost");
  property p_only; lane_valid |-> $past(write_strobe && !chip_select_low); endproperty
  a_only: assert property (p_only) else $error("write invented");
  property p_data; lane_valid |-> lane_data == ($past(parallel_lines) & lane_mask); endproperty
  a_data: assert property (p_data) else $error("lane data");
  property p_cmd; lane_valid |-> lane_cmd != $past(data_command_select); endproperty
  a_cmd: assert property (p_cmd) else $error("cmd flag");
  property p_hold; straps_valid |=> $stable(interface_mode) && $stable(lane_mask); endproperty
  a_hold: assert property (p_hold) else $error("mode moved");
  property p_fmt; straps_valid |-> reg_content_mode == |interface_mode; endproperty
  a_fmt: assert property (p_fmt) else $error("format");
  property p_id; serial_identity_bit |-> interface_mode == `MODE_SER3; endproperty
  a_id: assert property (p_id) else $error("identity");
  property p_pix; straps_valid && $changed(pixel_format_666) |-> lane_valid && !lane_cmd;
  endproperty
  a_pix: assert property (p_pix) else $error("pixel format");
  c_cmd: cover property (lane_valid && lane_cmd);
  c_ser3: cover property (serial_identity_bit);
  c_pix: cover property ($fell(pixel_format_666));
endmodule // host_mode_props
bind host_interface_mode_select host_mode_props host_mode_props_i (.*);

/* File: host_model.sv */
// Host side model of the parallel write port
`timescale 1ns/1ps
module host_model (
  input  wire logic   clk,   // Clock
  output logic        cs_n,  // Chip select, low
  output logic        dc,    // Data high, command low
  output logic        wr,    // Write strobe
  output logic [17:0] lines  // Data lines
);
  // Idle and deselected at time zero
  initial begin
    {cs_n, dc, wr, lines} = {3'h4, 18'h0_0000};
  end
  // Write held over one sampling edge, strobe left up for a following send
  task send(input logic c, d, input logic [17:0] v);
    {cs_n, dc, wr, lines} = {c, d, 1'b1, v};
    @(posedge clk);
    #1;
  endtask
  // Release: deselect, bus shows inverse
  task idle();
    {cs_n, wr, lines} = {2'h2, ~lines};
  endtask
endmodule // host_model

/* File: testbench.sv */
// Bench for host mode select
`timescale 1ns/1ps
`include "host_mode_defs.vh"
module testbench;
  logic        clk = 0, rst_n = 0, fmt = 1;
  logic [2:0]  ims = 0;
  wire         cs_n, dc, wr, rcm, idb, sv, lcmd, lv, pix;
  wire  [5:0]  mode;
  wire  [17:0] lines, mask, ldat;
  int          n_errors = 0, num_checks = 0, cyc = 0;
  logic [17:0] lanes [4] = '{`LANES_PAR18, `LANES_PAR9, `LANES_PAR16, `LANES_PAR8};
  // Clock, 40 ns
  always #20 clk = ~clk;
  host_model host_model_i (.clk(clk), .cs_n(cs_n), .dc(dc), .wr(wr), .lines(lines));
  host_interface_mode_select host_interface_mode_select_i (.clk(clk), .rst_n(rst_n),
    .format_select_strap(fmt), .interface_type_straps(ims), .chip_select_low(cs_n),
    .data_command_select(dc), .write_strobe(wr), .parallel_lines(lines),
    .reg_content_mode(rcm), .interface_mode(mode), .serial_identity_bit(idb),
    .straps_valid(sv), .lane_mask(mask), .lane_data(ldat), .lane_cmd(lcmd),
    .lane_valid(lv), .pixel_format_666(pix));
  // Compare one result, count and report a mismatch
  task chk(input string n, input logic [17:0] e, g);
    num_checks++;
    if (g !== e) begin
      n_errors++;
      $display("ERROR %s exp %h got %h", n, e, g);
    end
  endtask
  // Counts, verdict and end of run
  task wrap_up();
    $display("checks %0d errors %0d", num_checks, n_errors);
    if (n_errors == 0 && num_checks > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  // Reset with straps, wait past capture
  task start(input logic f, input logic [2:0] m);
    {rst_n, fmt, ims} = {1'b0, f, m};
    repeat (12) @(posedge clk);
    #1 rst_n = 1;
    repeat (3) @(posedge clk);
    #1;
    chk("early valid", 0, sv);
    @(posedge clk);
    #1;
    chk("straps valid", 1, sv);
    @(posedge clk);
    #1;
  endtask
  // Hang ceiling
  always @(posedge clk) begin
    cyc++;
    if (cyc == 2000) begin
      n_errors++;
      wrap_up();
    end
  end
  // Every strap code, then pixel format and command-parameter
  initial begin
    for (int i = 0; i < 8; i++) begin
      start(1, i[2:0]);
      ims = ~ims;
      host_model_i.send(0, 1, 18'h2_b6d5);
      chk("valid", i < 4, lv);
      chk("data", i < 4 ? 18'h2_b6d5 & lanes[i[1:0]] : 18'h0_0000, ldat);
      host_model_i.send(1, 1, 18'h1_ffff);
      chk("deselected", 0, lv);
      host_model_i.idle();
      chk("mode", i < 4 ? 6'h01 << i : i < 6 ? `MODE_SER3 : `MODE_SER4, mode);
      chk("mask", i < 4 ? lanes[i[1:0]] : 18'h0_0000, mask);
      chk("id", i == 5, idb);
      chk("fmt", 1, rcm);
    end
    start(1, 3'h0);
    chk("pix", 1, pix);
    host_model_i.send(0, 0, 18'h0_002e);
    chk("cmd", 1, lcmd);
    host_model_i.send(0, 1, 18'h1_feff);
    chk("data flag", 0, lcmd);
    chk("pix", 0, pix);
    host_model_i.send(0, 0, 18'h0_0030);
    host_model_i.send(0, 1, 18'h2_0000);
    chk("pix", 0, pix);
    host_model_i.send(0, 0, 18'h0_5c00);
    host_model_i.send(0, 1, 18'h0_0100);
    chk("pix", 1, pix);
    host_model_i.idle();
    start(0, 3'h0);
    host_model_i.send(0, 1, 18'h3_ffff);
    chk("cp valid", 0, lv);
    chk("cp mode", 0, mode);
    chk("cp fmt", 0, rcm);
    host_model_i.idle();
    wrap_up();
  end
endmodule // testbench
